// ==== core/urxb_pkg.sv ====
// Shared constants and types of the receive buffer and status block
package urxb_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [1:0] OFF_DATA = 2'h0;
	localparam logic [1:0] OFF_STATUS = 2'h1;
	localparam logic [1:0] OFF_CTRL_B = 2'h2;
	localparam logic [1:0] OFF_CTRL_C = 2'h3;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_RXC = 7;
	localparam int ST_FE = 4;
	localparam int ST_DOR = 3;
	localparam int ST_PE = 2;
	localparam int CB_IRQ_EN = 7;
	localparam int CB_RX_EN = 4;
	localparam int CB_SIZE2 = 2;
	localparam int CB_NINTH = 1;
	localparam int CC_PAR_EN = 5;
	localparam int CC_PAR_ODD = 4;
	localparam int CC_STOP2 = 3;
	localparam int CC_SIZE_HI = 2;
	localparam int CC_SIZE_LO = 1;
	// ----------------------------------------
	// Sizes, codes and reset values
	// ----------------------------------------
	localparam int FIFO_DEPTH = 2;
	localparam logic [1:0] FIFO_FULL = 2'h2;
	localparam logic [2:0] SIZE_5 = 3'h0;
	localparam logic [2:0] SIZE_6 = 3'h1;
	localparam logic [2:0] SIZE_7 = 3'h2;
	localparam logic [2:0] SIZE_9 = 3'h7;
	localparam logic [2:0] SIZE_RESET = 3'h3;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [8:0] data;
		logic parity;
		logic stop;
	} urxb_frame_t;
	typedef struct packed {
		logic [8:0] data;
		logic fe;
		logic dor;
		logic pe;
	} urxb_entry_t;
	typedef struct packed {
		logic [2:0] size;
		logic par_en;
		logic par_odd;
		logic stop2;
	} urxb_cfg_t;
endpackage

// ==== core/urxb_top.sv ====
// Receive buffer, status flags and parity check of the serial receiver
`timescale 1ns/1ps

// Summary of operation
// [RQ1] Receive-complete flag is one exactly while the buffer holds unread characters.
// [RQ2] Clearing receiver enable flushes every buffer entry; receive-complete reads zero.
// [RQ3] Interrupt request stays high while receive-complete and its enable are set.
// [RQ4] A data read removes the oldest character; flag clears when none remain.
// [RQ5] A slot freed by a data read takes a new frame at once.
// [RQ6] Error flags travel with each character; status shows the oldest one's.
// [RQ7] Software reads status before data, since the data read advances.
// [RQ8] Status writes leave the three error flags untouched.
// [RQ9] Software writes zero into the error flag positions of status.
// [RQ10] No interrupt comes from the error flags.
// [RQ11] Frame error set when first stop bit was zero, clear when one.
// [RQ12] Only the first stop bit counts; stop count selection is ignored.
// [RQ13] Overrun: buffer full, character waiting, new start bit; waiting one lost.
// [RQ14] Overrun marks frames lost before the next character read.
// [RQ15] Overrun clears when a frame moves into the buffer successfully.
// [RQ16] Parity check runs only when enabled; a second bit selects odd or even.
// [RQ17] Checker compares data parity with received parity bit, stores mismatch.
// [RQ18] Parity error only for mismatch with checking enabled at reception.
// [RQ19] Parity error flag reads zero while parity checking is disabled.
// [RQ20] Disabling the receiver acts at once and drops partial reception.
// [RQ21] Disabled receiver releases the receive pin to its port function.
// [RQ22] Software flushes by reading data until receive-complete reads zero.
// [RQ23] Ninth bit buffered per character, shown in a control bit.
// [RQ24] Unused upper data bits of short frames read as zero.
// [RQ25] Parity select zero means even, one means odd.
// [RQ26] Reset empties the buffer and clears all receive flags.
module urxb_top
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Register port
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_rdata,
	// Shift register side
	input wire urxb_pkg::urxb_frame_t i_frame,
	input wire logic i_frame_done,
	input wire logic i_start_seen,
	output urxb_pkg::urxb_cfg_t o_cfg,
	output logic o_rx_enable,
	// Interrupt request
	output logic o_rx_irq
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	urxb_pkg::urxb_entry_t mem_r [0:urxb_pkg::FIFO_DEPTH-1];
	urxb_pkg::urxb_entry_t hold_r;
	urxb_pkg::urxb_cfg_t cfg_r;
	logic hold_valid_r;
	logic [1:0] count_r;
	logic rd_ptr_r;
	logic dor_pend_r;
	logic rx_en_r;
	logic irq_en_r;
	logic [7:0] rdata_r;
	logic irq_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire sel_data = (i_addr == urxb_pkg::OFF_DATA);
	wire sel_status = (i_addr == urxb_pkg::OFF_STATUS); // RQ8
	wire sel_ctrl_b = (i_addr == urxb_pkg::OFF_CTRL_B);
	wire sel_ctrl_c = (i_addr == urxb_pkg::OFF_CTRL_C);
	wire wr_ctrl_b = i_write && sel_ctrl_b;
	wire wr_ctrl_c = i_write && sel_ctrl_c;
	wire rd_data = i_read && sel_data;

	wire rx_en_nxt = wr_ctrl_b ? i_wdata[urxb_pkg::CB_RX_EN] : rx_en_r;
	wire irq_en_nxt = wr_ctrl_b ? i_wdata[urxb_pkg::CB_IRQ_EN] : irq_en_r;
	wire flush = !rx_en_nxt; // RQ2 RQ20
	wire rxc = (count_r != 2'h0); // RQ1

	// ----------------------------------------
	// Buffer movement
	// ----------------------------------------
	wire pop = rd_data && rxc; // RQ4
	wire space = (count_r != urxb_pkg::FIFO_FULL) || pop; // RQ5
	wire push = hold_valid_r && space && rx_en_r;
	wire overrun_ev = rx_en_r && hold_valid_r && !space && i_start_seen; // RQ13
	wire lost_ev = overrun_ev || (rx_en_r && i_frame_done && hold_valid_r && !push);
	wire wr_idx = rd_ptr_r ^ count_r[0];

	logic [1:0] count_nxt;
	always_comb
	begin
		count_nxt = count_r;
		if (flush)
			count_nxt = 2'h0; // RQ2
		else if (push && !pop)
			count_nxt = count_r + 2'h1;
		else if (pop && !push)
			count_nxt = count_r - 2'h1; // RQ4
	end

	// ----------------------------------------
	// Frame capture and checking
	// ----------------------------------------
	function automatic logic [8:0] size_mask(input logic [2:0] size);
		logic [8:0] m;
		m = 9'h0ff;
		if (size == urxb_pkg::SIZE_5)
			m = 9'h01f;
		else if (size == urxb_pkg::SIZE_6)
			m = 9'h03f;
		else if (size == urxb_pkg::SIZE_7)
			m = 9'h07f;
		else if (size == urxb_pkg::SIZE_9)
			m = 9'h1ff;
		return m;
	endfunction

	wire [8:0] masked = i_frame.data & size_mask(cfg_r.size); // RQ24 RQ23
	wire par_calc = (^masked) ^ cfg_r.par_odd; // RQ25
	wire par_bad = (par_calc != i_frame.parity) && cfg_r.par_en; // RQ17 RQ18 RQ16

	urxb_pkg::urxb_entry_t captured;
	assign captured.data = masked;
	assign captured.fe = !i_frame.stop; // RQ11 RQ12
	assign captured.dor = 1'b0;
	assign captured.pe = par_bad;

	urxb_pkg::urxb_entry_t pushed;
	assign pushed.data = hold_r.data;
	assign pushed.fe = hold_r.fe;
	assign pushed.dor = dor_pend_r; // RQ14
	assign pushed.pe = hold_r.pe;

	// ----------------------------------------
	// Register read view
	// ----------------------------------------
	urxb_pkg::urxb_entry_t head;
	assign head = rxc ? mem_r[rd_ptr_r] : '0;

	logic [7:0] status_view;
	logic [7:0] ctrl_b_view;
	logic [7:0] ctrl_c_view;
	always_comb
	begin
		status_view = 8'h00;
		status_view[urxb_pkg::ST_RXC] = rxc;
		status_view[urxb_pkg::ST_FE] = head.fe; // RQ6
		status_view[urxb_pkg::ST_DOR] = head.dor;
		status_view[urxb_pkg::ST_PE] = head.pe && cfg_r.par_en; // RQ19
		ctrl_b_view = 8'h00;
		ctrl_b_view[urxb_pkg::CB_IRQ_EN] = irq_en_r;
		ctrl_b_view[urxb_pkg::CB_RX_EN] = rx_en_r;
		ctrl_b_view[urxb_pkg::CB_SIZE2] = cfg_r.size[2];
		ctrl_b_view[urxb_pkg::CB_NINTH] = head.data[8]; // RQ23
		ctrl_c_view = 8'h00;
		ctrl_c_view[urxb_pkg::CC_PAR_EN] = cfg_r.par_en;
		ctrl_c_view[urxb_pkg::CC_PAR_ODD] = cfg_r.par_odd;
		ctrl_c_view[urxb_pkg::CC_STOP2] = cfg_r.stop2;
		ctrl_c_view[urxb_pkg::CC_SIZE_HI] = cfg_r.size[1];
		ctrl_c_view[urxb_pkg::CC_SIZE_LO] = cfg_r.size[0];
	end

	wire [7:0] rdata_sel = sel_data ? head.data[7:0] :
		sel_status ? status_view :
		sel_ctrl_b ? ctrl_b_view : ctrl_c_view;
	wire [7:0] rdata_nxt = i_read ? rdata_sel : urxb_pkg::RDATA_RESET;

	urxb_pkg::urxb_cfg_t cfg_nxt;
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (wr_ctrl_b)
			cfg_nxt.size[2] = i_wdata[urxb_pkg::CB_SIZE2];
		if (wr_ctrl_c)
		begin
			cfg_nxt.par_en = i_wdata[urxb_pkg::CC_PAR_EN];
			cfg_nxt.par_odd = i_wdata[urxb_pkg::CC_PAR_ODD];
			cfg_nxt.stop2 = i_wdata[urxb_pkg::CC_STOP2];
			cfg_nxt.size[1] = i_wdata[urxb_pkg::CC_SIZE_HI];
			cfg_nxt.size[0] = i_wdata[urxb_pkg::CC_SIZE_LO];
		end
	end

	// Status writes touch nothing: the error flags live in the buffer
	wire irq_nxt = rx_en_nxt && (count_nxt != 2'h0) && irq_en_nxt; // RQ3 RQ10

	// ----------------------------------------
	// Sequential logic
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			count_r <= 2'h0; // RQ26
			rd_ptr_r <= 1'b0;
			dor_pend_r <= 1'b0;
			hold_valid_r <= 1'b0;
			hold_r <= '0;
		end
		else
		begin
			count_r <= count_nxt;
			if (flush)
				rd_ptr_r <= 1'b0;
			else if (pop)
				rd_ptr_r <= !rd_ptr_r;
			if (flush)
				dor_pend_r <= 1'b0;
			else if (lost_ev)
				dor_pend_r <= 1'b1; // RQ13
			else if (push)
				dor_pend_r <= 1'b0; // RQ15
			if (flush)
				hold_valid_r <= 1'b0; // RQ20
			else if (i_frame_done)
				hold_valid_r <= 1'b1;
			else if (push || overrun_ev)
				hold_valid_r <= 1'b0;
			if (i_frame_done)
				hold_r <= captured;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < urxb_pkg::FIFO_DEPTH; i++)
				mem_r[i] <= '0;
		end
		else if (push)
			mem_r[wr_idx] <= pushed; // RQ6 RQ5
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cfg_r <= '{size: urxb_pkg::SIZE_RESET, default: 1'b0};
			rx_en_r <= 1'b0;
			irq_en_r <= 1'b0;
			rdata_r <= urxb_pkg::RDATA_RESET;
			irq_r <= 1'b0;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			rx_en_r <= rx_en_nxt;
			irq_en_r <= irq_en_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt; // RQ3
		end
	end

	assign o_rdata = rdata_r;
	assign o_cfg = cfg_r;
	assign o_rx_enable = rx_en_r; // RQ21
	assign o_rx_irq = irq_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_push_empty;
		push && !pop && !flush && (count_r == 2'h0);
	endsequence
	property p_rxc_set;
		s_push_empty |=> rxc ##0 (count_r == 2'h1);
	endproperty
	a_rxc_set: assert property (p_rxc_set) else $error("flag not set after store"); // RQ1

	property p_flush;
		(wr_ctrl_b && !i_wdata[urxb_pkg::CB_RX_EN]) |=> !rxc && !hold_valid_r && !o_rx_irq;
	endproperty
	a_flush: assert property (p_flush) else $error("disable did not flush"); // RQ2

	property p_irq;
		o_rx_irq == (rxc && irq_en_r && rx_en_r);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch with flag and enable"); // RQ3

	property p_pop_last;
		(pop && !push && count_r == 2'h1 && rx_en_nxt) |=> !rxc;
	endproperty
	a_pop_last: assert property (p_pop_last) else $error("flag stays after last read"); // RQ4

	property p_slot_reuse;
		(pop && hold_valid_r && rx_en_r && rx_en_nxt && count_r == urxb_pkg::FIFO_FULL)
			|=> (count_r == urxb_pkg::FIFO_FULL);
	endproperty
	a_slot_reuse: assert property (p_slot_reuse) else $error("freed slot not reused"); // RQ5

	property p_err_write;
		(i_write && sel_status && !push && !flush) |=> $stable(head.fe) && $stable(head.dor);
	endproperty
	a_err_write: assert property (p_err_write) else $error("status write changed flags"); // RQ8

	property p_fe;
		i_frame_done |=> (hold_r.fe == !$past(i_frame.stop));
	endproperty
	a_fe: assert property (p_fe) else $error("frame error wrong"); // RQ11

	sequence s_overrun;
		overrun_ev && rx_en_nxt && !i_frame_done;
	endsequence
	property p_overrun;
		s_overrun |=> dor_pend_r && !hold_valid_r;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not caught"); // RQ13

	property p_dor_clear;
		(push && !lost_ev) |=> !dor_pend_r;
	endproperty
	a_dor_clear: assert property (p_dor_clear) else $error("overrun not cleared"); // RQ15

	property p_pe_off;
		(i_read && sel_status && !cfg_r.par_en) |=> !o_rdata[urxb_pkg::ST_PE];
	endproperty
	a_pe_off: assert property (p_pe_off) else $error("parity flag while disabled"); // RQ19

	property p_short;
		(i_read && sel_data && cfg_r.size == urxb_pkg::SIZE_5) |=> (o_rdata[7:5] == 3'h0);
	endproperty
	a_short: assert property (p_short) else $error("upper bits not zero"); // RQ24

	property p_pe_capture;
		(i_frame_done && !cfg_r.par_en) |=> !hold_r.pe;
	endproperty
	a_pe_capture: assert property (p_pe_capture) else $error("parity error while off"); // RQ18

	property p_no_err_irq;
		(!rxc || !irq_en_r) |-> !o_rx_irq;
	endproperty
	a_no_err_irq: assert property (p_no_err_irq) else $error("irq without flag"); // RQ10

	property p_ninth;
		(i_read && sel_ctrl_b) |=> (o_rdata[urxb_pkg::CB_NINTH] == $past(head.data[8]));
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit view wrong"); // RQ23

endmodule

// ==== verification/testbench.sv ====
// Self-checking bench of the receive buffer and status block
`timescale 1ns/1ps
module testbench;
	logic i_clock;
	logic i_rst_n;
	logic [1:0] i_addr;
	logic [7:0] i_wdata;
	logic i_write;
	logic i_read;
	logic [7:0] o_rdata;
	urxb_pkg::urxb_frame_t i_frame;
	logic i_frame_done;
	logic i_start_seen;
	urxb_pkg::urxb_cfg_t o_cfg;
	logic o_rx_enable;
	logic o_rx_irq;
	int fail_count = 0;
	int samples_checked = 0;
	logic [7:0] exp_q[$];
	logic [7:0] e;
	logic [7:0] d;
	logic [7:0] v[4];
	logic rd_pend = 1'b0;
	urxb_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
		.i_frame(i_frame), .i_frame_done(i_frame_done), .i_start_seen(i_start_seen),
		.o_cfg(o_cfg), .o_rx_enable(o_rx_enable), .o_rx_irq(o_rx_irq));
	urxb_far_end far (.i_clock(i_clock), .o_frame(i_frame), .o_done(i_frame_done),
		.o_start(i_start_seen));
	// ----------------------------------------
	// Clock, checks and closing
	// ----------------------------------------
	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		samples_checked++;
		if (g !== x)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 20000; i++)
			@(posedge i_clock);
		fail_count++;
		report_and_stop();
	end
	// Read data stand in the cycle after the strobe only
	initial
	forever
	begin
		@(posedge i_clock);
		if (rd_pend)
		begin
			e = exp_q.pop_front();
			chk("rdata", e, o_rdata);
		end
		rd_pend = i_read;
	end
	// ----------------------------------------
	// Register bus master
	// ----------------------------------------
	task automatic wr(input logic [1:0] a, input logic [7:0] x);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= x;
		i_write <= 1'b1;
		@(posedge i_clock);
		i_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		@(posedge i_clock);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		i_rst_n = 1'b0;
		i_addr = 2'h0;
		i_wdata = 8'h00;
		i_write = 1'b0;
		i_read = 1'b0;
		void'($urandom(32'h2140b44a));
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(urxb_pkg::OFF_STATUS, 8'h00);
		rd(urxb_pkg::OFF_CTRL_B, 8'h00);
		rd(urxb_pkg::OFF_CTRL_C, 8'h06);
		wr(urxb_pkg::OFF_CTRL_B, 8'h90);
		d = 8'($urandom);
		far.send({1'b0, d}, 1'b0, 1'b1);
		idle(2);
		chk("irq", 8'h01, {7'h0, o_rx_irq});
		rd(urxb_pkg::OFF_STATUS, 8'h80);
		rd(urxb_pkg::OFF_DATA, d);
		idle(2);
		chk("irq", 8'h00, {7'h0, o_rx_irq});
		// Two stop bits selected: only the first one decides
		wr(urxb_pkg::OFF_CTRL_C, 8'h0e);
		rd(urxb_pkg::OFF_CTRL_C, 8'h0e);
		far.send({1'b0, d}, 1'b0, 1'b0);
		idle(2);
		rd(urxb_pkg::OFF_STATUS, 8'h90);
		wr(urxb_pkg::OFF_STATUS, 8'h00);
		rd(urxb_pkg::OFF_STATUS, 8'h90);
		chk("irq", 8'h01, {7'h0, o_rx_irq});
		rd(urxb_pkg::OFF_DATA, d);
		// Parity of both kinds, good and bad
		for (int k = 0; k < 4; k++)
		begin
			wr(urxb_pkg::OFF_CTRL_C, k[0] ? 8'h36 : 8'h26);
			idle(1);
			chk("cfg", {2'h0, 3'h3, 1'b1, k[0], 1'b0}, {2'h0, o_cfg});
			d = 8'($urandom);
			far.send({1'b0, d}, ^d ^ k[0] ^ k[1], 1'b1);
			idle(2);
			rd(urxb_pkg::OFF_STATUS, k[1] ? 8'h84 : 8'h80);
			rd(urxb_pkg::OFF_DATA, d);
		end
		far.send({1'b0, d}, ^d, 1'b1);
		idle(2);
		wr(urxb_pkg::OFF_CTRL_C, 8'h06);
		rd(urxb_pkg::OFF_STATUS, 8'h80);
		rd(urxb_pkg::OFF_DATA, d);
		// Overrun: two buffered, one waiting, then a new start
		foreach (v[i])
			v[i] = 8'($urandom);
		far.send({1'b0, v[0]}, 1'b0, 1'b1);
		far.send({1'b0, v[1]}, 1'b0, 1'b1);
		far.send({1'b0, v[2]}, 1'b0, 1'b1);
		far.start_bit();
		far.send({1'b0, v[3]}, 1'b0, 1'b1);
		idle(2);
		rd(urxb_pkg::OFF_STATUS, 8'h80);
		rd(urxb_pkg::OFF_DATA, v[0]);
		rd(urxb_pkg::OFF_STATUS, 8'h80);
		rd(urxb_pkg::OFF_DATA, v[1]);
		rd(urxb_pkg::OFF_STATUS, 8'h88);
		rd(urxb_pkg::OFF_DATA, v[3]);
		far.send({1'b0, v[0]}, 1'b0, 1'b1);
		idle(2);
		rd(urxb_pkg::OFF_STATUS, 8'h80);
		rd(urxb_pkg::OFF_DATA, v[0]);
		rd(urxb_pkg::OFF_STATUS, 8'h00);
		// Disable with a full buffer and a waiting frame
		for (int i = 0; i < 3; i++)
			far.send({1'b0, v[i]}, 1'b0, 1'b1);
		wr(urxb_pkg::OFF_CTRL_B, 8'h80);
		idle(2);
		chk("irq", 8'h00, {7'h0, o_rx_irq});
		chk("rx_enable", 8'h00, {7'h0, o_rx_enable});
		rd(urxb_pkg::OFF_STATUS, 8'h00);
		far.send({1'b0, v[3]}, 1'b0, 1'b1);
		wr(urxb_pkg::OFF_CTRL_B, 8'h90);
		idle(2);
		rd(urxb_pkg::OFF_STATUS, 8'h00);
		chk("rx_enable", 8'h01, {7'h0, o_rx_enable});
		// Five to seven-bit characters, then nine-bit with interrupt disabled
		for (int s = 0; s < 3; s++)
		begin
			wr(urxb_pkg::OFF_CTRL_C, 8'(s << 1));
			far.send(9'h1ff, 1'b0, 1'b1);
			idle(2);
			rd(urxb_pkg::OFF_DATA, 8'hff >> (3 - s));
		end
		wr(urxb_pkg::OFF_CTRL_B, 8'h14);
		wr(urxb_pkg::OFF_CTRL_C, 8'h06);
		far.send(9'h1a5, 1'b0, 1'b1);
		idle(2);
		chk("irq", 8'h00, {7'h0, o_rx_irq});
		rd(urxb_pkg::OFF_CTRL_B, 8'h16);
		rd(urxb_pkg::OFF_DATA, 8'ha5);
		idle(3);
		report_and_stop();
	end
endmodule

// ==== verification/urxb_far_end.sv ====
// Remote transmitter model that hands completed frames to the receiver
`timescale 1ns/1ps
module urxb_far_end
(
	// Clock
	input wire logic i_clock,
	// Frame side
	output urxb_pkg::urxb_frame_t o_frame,
	output logic o_done,
	output logic o_start
);
	initial
	begin
		o_frame = '0;
		o_done = 1'b0;
		o_start = 1'b0;
	end
	// Only the first stop bit is carried; the frame is garbled once handed over
	task automatic send(input logic [8:0] d, input logic p, input logic s);
		@(posedge i_clock);
		o_frame <= {d, p, s};
		o_done <= 1'b1;
		@(posedge i_clock);
		o_done <= 1'b0;
		o_frame <= ~{d, p, s};
	endtask
	task automatic start_bit();
		@(posedge i_clock);
		o_start <= 1'b1;
		@(posedge i_clock);
		o_start <= 1'b0;
	endtask
endmodule
